//--- hw/rst_mode_pkg.sv
// Constants and carrier types for the reset pin and mode-select pin block
package rst_mode_pkg;

   localparam logic [7:0] OFS_SYSOPT = 8'h00;
   localparam logic [7:0] OFS_CAUSE = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_PINCTL = 8'h10;
   localparam logic [7:0] OFS_KEYPAD = 8'h14;
   localparam logic [7:0] OFS_PORT = 8'h18;
   localparam logic [7:0] OFS_MODE = 8'h1C;

   // Reset cause bit positions
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_WDOG = 2;
   localparam int CAUSE_ILOP = 3;
   localparam int CAUSE_ILAD = 4;
   localparam int CAUSE_LVD = 5;
   localparam int CAUSE_W = 6;
   localparam int INT_SRC_W = 4;

   // Interrupt event bit positions
   localparam int EV_DBG_EDGE = 0;
   localparam int EV_BIT_DONE = 1;
   localparam int EV_W = 2;

   // Timing counts
   localparam int RST_DRIVE_CYC = 34;
   localparam int RST_SAMPLE_CYC = 38;
   localparam int DBG_BIT_CYC = 16;
   localparam int SELF_RST_DIV_DEF = 50;

   typedef struct packed {
      logic rtiSel;
      logic dbgPinEn;
      logic rstPinEn;
   } sysopt_t;
   localparam sysopt_t SYSOPT_RST = 3'h3;

   typedef struct packed {
      logic irqEdge;
      logic ext_interrupt_pin_enable;
      logic dbgData;
      logic rstData;
   } pinctl_t;
   localparam pinctl_t PINCTL_RST = 4'h3;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahbReq_t;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } ahbRsp_t;

   typedef struct packed {
      logic rstOut;
      logic rstOe;
      logic rstPullUp;
      logic dbgOut;
      logic dbgOe;
      logic dbgPullUp;
   } pinDrv_t;

   typedef struct packed {
      logic [3:0] kpPullUp;
      logic [3:0] kpPullDn;
      logic irqPullUp;
      logic irqPullDn;
      logic [7:0] portPullUp;
   } pulls_t;

   typedef enum logic [1:0] {SEQ_RUN, SEQ_DRIVE, SEQ_WAIT} seq_t;

endpackage

//--- hw/reset_pin_mode_select.sv
// Reset pin sequencer, mode-select sampling, pin control and clock enables
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module reset_pin_mode_select #(
   parameter int SELF_RST_DIV = rst_mode_pkg::SELF_RST_DIV_DEF
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire rst_mode_pkg::ahbReq_t ahbReq,
   output var rst_mode_pkg::ahbRsp_t ahbRsp,
   input wire logic rstPinIn,
   input wire logic dbgPinIn,
   input wire logic rtiOscIn,
   input wire logic [rst_mode_pkg::INT_SRC_W-1:0] intRstReq,
   input wire logic dbgDriveLow,
   input wire logic dbgSpeedup,
   output var rst_mode_pkg::pinDrv_t pinDrv,
   output var rst_mode_pkg::pulls_t pulls,
   output logic mcuRst,
   output logic bgMode,
   output logic cpuClkEn,
   output logic busClkEn,
   output logic rtiClkEn,
   output logic dbgBitTick,
   output logic irq
);
   import rst_mode_pkg::*;

   if (SELF_RST_DIV < 2 || SELF_RST_DIV > 65536) begin : g_chk
      $error("SELF_RST_DIV must lie in 2..65536");
   end

   localparam logic [15:0] DIV_LAST = 16'(SELF_RST_DIV - 1);
   localparam logic [5:0] DRIVE_LAST = 6'(RST_DRIVE_CYC - 1);
   localparam logic [5:0] SAMPLE_LAST = 6'(RST_SAMPLE_CYC - 1);
   localparam logic [4:0] BIT_LAST = 5'(DBG_BIT_CYC - 1);

   typedef struct packed {
      seq_t seq;
      logic [15:0] divCnt;
      logic [5:0] cnt;
      logic [CAUSE_W-1:0] pendCause;
      logic [CAUSE_W-1:0] cause;
      logic [1:0] rstS;
      logic [1:0] dbgS;
      logic [1:0] rtiS;
      logic dbgPrev;
      logic rtiPrev;
      sysopt_t sysopt;
      pinctl_t pinctl;
      logic [3:0] kpEn;
      logic [3:0] kpEdg;
      logic [7:0] pue;
      logic [7:0] dir;
      logic [EV_W-1:0] stat;
      logic [EV_W-1:0] mask;
      logic wrPend;
      logic [7:0] wrAddr;
      ahbRsp_t rsp;
      logic busEn;
      logic rtiEn;
      logic bgMode;
      logic mcuRst;
      logic cpuEn;
      logic bitBusy;
      logic [4:0] bitCnt;
      logic bitTick;
      pinDrv_t pins;
      pulls_t pulls;
      logic irq;
   } st_t;

   st_t s_q;
   st_t s_d;

   logic selfEn;
   logic extReq;
   logic anyInt;
   logic [CAUSE_W-1:0] intCause;
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] statClr;
   logic accept;
   logic [7:0] aAddr;
   logic [31:0] rdMux;
   logic startSeq;

   always_comb begin
      s_d = s_q;
      ev = '0;
      statClr = '0;
      rdMux = 32'h0000_0000;
      intCause = '0;

      // Synchronisers; only the second stage is read by logic
      s_d.rstS = {s_q.rstS[0], rstPinIn};
      s_d.dbgS = {s_q.dbgS[0], dbgPinIn};
      s_d.rtiS = {s_q.rtiS[0], rtiOscIn};
      s_d.dbgPrev = s_q.dbgS[1];
      s_d.rtiPrev = s_q.rtiS[1];

      // Self-reset clock as an enable pulse from a divider
      selfEn = (s_q.divCnt == DIV_LAST);
      s_d.divCnt = selfEn ? 16'h0000 : s_q.divCnt + 16'h0001;

      // CPU at oscillator rate, bus at half of it
      s_d.busEn = ~s_q.busEn;
      s_d.rtiEn = s_q.sysopt.rtiSel ? 1'b1 : (s_q.rtiS[1] & ~s_q.rtiPrev);

      // Internal request priority: lowest cause position wins
      anyInt = |intRstReq;
      for (int i = INT_SRC_W - 1; i >= 0; i--) begin
         if (intRstReq[i]) begin
            intCause = '0;
            intCause[CAUSE_WDOG + i] = 1'b1;
         end
      end
      extReq = s_q.sysopt.rstPinEn & ~s_q.rstS[1];
      startSeq = (s_q.seq == SEQ_RUN) & (anyInt | extReq);

      s_d.bitTick = 1'b0;
      case (s_q.seq)
         SEQ_RUN: begin
            if (startSeq) begin
               s_d.seq = SEQ_DRIVE;
               s_d.cnt = '0;
               s_d.mcuRst = 1'b1;
               s_d.pendCause = anyInt ? intCause : CAUSE_W'(1 << CAUSE_PIN);
            end
         end
         SEQ_DRIVE: begin
            if (selfEn) begin
               s_d.cnt = s_q.cnt + 6'h01;
               if (s_q.cnt == DRIVE_LAST) begin
                  s_d.seq = SEQ_WAIT;
                  s_d.cnt = '0;
               end
            end
         end
         SEQ_WAIT: begin
            if (selfEn) begin
               s_d.cnt = s_q.cnt + 6'h01;
               if (s_q.cnt == SAMPLE_LAST) begin
                  s_d.seq = SEQ_RUN;
                  s_d.mcuRst = 1'b0;
                  // Low sample means someone outside still holds the pin
                  s_d.cause = s_q.rstS[1] ? s_q.pendCause
                                          : CAUSE_W'(1 << CAUSE_PIN);
                  s_d.bgMode = ~s_q.dbgS[1];
               end
            end
         end
         default: begin
            s_d.seq = SEQ_RUN;
         end
      endcase

      // Debug bit timer, clocked at the top debug rate (bus rate)
      if (s_q.seq == SEQ_RUN && s_q.sysopt.dbgPinEn) begin
         if (!s_q.bitBusy && s_q.dbgPrev && !s_q.dbgS[1]) begin
            s_d.bitBusy = 1'b1;
            s_d.bitCnt = '0;
            ev[EV_DBG_EDGE] = 1'b1;
         end else if (s_q.bitBusy && s_q.busEn) begin
            s_d.bitCnt = s_q.bitCnt + 5'h01;
            if (s_q.bitCnt == BIT_LAST) begin
               s_d.bitBusy = 1'b0;
               s_d.bitTick = 1'b1;
               ev[EV_BIT_DONE] = 1'b1;
            end
         end
      end else begin
         s_d.bitBusy = 1'b0;
      end

      // Bus slave: zero wait states, read data registered at address phase
      accept = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;
      aAddr = ahbReq.haddr[7:0];
      case (aAddr)
         OFS_SYSOPT: rdMux = {29'h0, s_q.sysopt};
         OFS_CAUSE: rdMux = {26'h0, s_q.cause};
         OFS_IRQ_STAT: rdMux = {30'h0, s_q.stat};
         OFS_IRQ_MASK: rdMux = {30'h0, s_q.mask};
         OFS_PINCTL: rdMux = {28'h0, s_q.pinctl};
         OFS_KEYPAD: rdMux = {24'h0, s_q.kpEdg, s_q.kpEn};
         OFS_PORT: rdMux = {16'h0, s_q.dir, s_q.pue};
         OFS_MODE: rdMux = {30'h0, s_q.mcuRst, s_q.bgMode};
         default: rdMux = 32'h0000_0000;
      endcase
      s_d.wrPend = accept & ahbReq.hwrite;
      s_d.wrAddr = aAddr;
      if (accept && !ahbReq.hwrite) begin
         s_d.rsp.hrdata = rdMux;
         if (aAddr == OFS_IRQ_STAT) begin
            statClr = s_q.stat;
         end
      end
      if (s_q.wrPend) begin
         case (s_q.wrAddr)
            OFS_SYSOPT: s_d.sysopt = sysopt_t'(ahbReq.hwdata[2:0]);
            OFS_IRQ_MASK: s_d.mask = ahbReq.hwdata[EV_W-1:0];
            OFS_PINCTL: s_d.pinctl = pinctl_t'(ahbReq.hwdata[3:0]);
            OFS_KEYPAD: {s_d.kpEdg, s_d.kpEn} = ahbReq.hwdata[7:0];
            OFS_PORT: {s_d.dir, s_d.pue} = ahbReq.hwdata[15:0];
            default: s_d.wrPend = s_d.wrPend;
         endcase
      end
      s_d.rsp.hreadyout = 1'b1;
      s_d.rsp.hresp = 1'b0;

      // Sticky events; a new event beats a read clear in the same cycle
      s_d.stat = (s_q.stat & ~statClr) | ev;

      // Any reset returns the configuration to defaults
      if (startSeq) begin
         s_d.sysopt = SYSOPT_RST;
         s_d.pinctl = PINCTL_RST;
         s_d.kpEn = '0;
         s_d.kpEdg = '0;
         s_d.pue = '0;
         s_d.dir = '0;
         s_d.stat = '0;
         s_d.mask = '0;
         s_d.wrPend = 1'b0;
      end
      s_d.irq = |(s_d.stat & s_d.mask);

      // Reset pin: driven low in the drive phase, then input or port
      if (s_d.seq == SEQ_DRIVE) begin
         s_d.pins.rstOe = 1'b1;
         s_d.pins.rstOut = 1'b0;
      end else if (s_d.seq == SEQ_WAIT || s_d.sysopt.rstPinEn) begin
         s_d.pins.rstOe = 1'b0;
         s_d.pins.rstOut = 1'b0;
      end else begin
         s_d.pins.rstOe = 1'b1;
         s_d.pins.rstOut = s_d.pinctl.rstData;
      end
      s_d.pins.rstPullUp = s_d.sysopt.rstPinEn;

      // Debug pin: mode input in reset, open drain with speedup or port after
      if (s_d.mcuRst) begin
         s_d.pins.dbgOe = 1'b0;
         s_d.pins.dbgOut = 1'b0;
      end else if (s_d.sysopt.dbgPinEn) begin
         // Low wins over speedup so a driven high never fights a low
         s_d.pins.dbgOe = dbgDriveLow | dbgSpeedup;
         s_d.pins.dbgOut = dbgSpeedup & ~dbgDriveLow;
      end else begin
         s_d.pins.dbgOe = 1'b1;
         s_d.pins.dbgOut = s_d.pinctl.dbgData;
      end
      s_d.pins.dbgPullUp = s_d.sysopt.dbgPinEn | s_d.mcuRst;

      // Pull devices
      for (int k = 0; k < 4; k++) begin
         s_d.pulls.kpPullDn[k] = s_d.pue[4 + k] & ~s_d.dir[4 + k]
                                 & s_d.kpEn[k] & s_d.kpEdg[k];
         s_d.pulls.kpPullUp[k] = s_d.pue[4 + k] & ~s_d.dir[4 + k]
                                 & ~(s_d.kpEn[k] & s_d.kpEdg[k]);
      end
      s_d.pulls.irqPullDn = s_d.pinctl.ext_interrupt_pin_enable & s_d.pinctl.irqEdge;
      s_d.pulls.irqPullUp = s_d.pinctl.ext_interrupt_pin_enable & ~s_d.pinctl.irqEdge;
      s_d.pulls.portPullUp = s_d.pue & ~s_d.dir;
      s_d.cpuEn = ~s_d.mcuRst;

      if (sys_rst) begin
         s_d = '0;
         s_d.seq = SEQ_DRIVE;
         s_d.mcuRst = 1'b1;
         s_d.pendCause = CAUSE_W'(1 << CAUSE_POR);
         s_d.sysopt = SYSOPT_RST;
         s_d.pinctl = PINCTL_RST;
         s_d.rsp.hreadyout = 1'b1;
         s_d.rstS = 2'h3;
         s_d.dbgS = 2'h3;
         s_d.pins.rstOe = 1'b1;
         s_d.pins.rstPullUp = 1'b1;
         s_d.pins.dbgPullUp = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   assign ahbRsp = s_q.rsp;
   assign pinDrv = s_q.pins;
   assign pulls = s_q.pulls;
   assign mcuRst = s_q.mcuRst;
   assign bgMode = s_q.bgMode;
   assign cpuClkEn = s_q.cpuEn;
   assign busClkEn = s_q.busEn;
   assign rtiClkEn = s_q.rtiEn;
   assign dbgBitTick = s_q.bitTick;
   assign irq = s_q.irq;

endmodule

`default_nettype wire

//--- testbench/reset_pin_mode_select_properties.sv
// Port-level assertions for the reset pin and mode-select block
`timescale 1ns/1ps
`default_nettype none
module reset_pin_mode_select_properties #(
   parameter int SELF_RST_DIV = 2
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic dbgPinIn,
   input wire logic dbgDriveLow,
   input wire rst_mode_pkg::pinDrv_t pinDrv,
   input wire logic mcuRst,
   input wire logic bgMode,
   input wire logic busClkEn,
   input wire logic dbgBitTick
);
   import rst_mode_pkg::*;
   localparam int SLO = 38 * SELF_RST_DIV - 2;
   localparam int SHI = 38 * SELF_RST_DIV + 3;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   AST_DRIVE_LOW: assert property (mcuRst && pinDrv.rstOe |-> !pinDrv.rstOut)
      else $error("reset pin driven high");
   AST_SAMPLE_GAP: assert property ($fell(pinDrv.rstOe) && mcuRst |-> ##[SLO:SHI] $fell(mcuRst))
      else $error("sample point off");
   AST_RST_PULL: assert property (mcuRst |-> pinDrv.rstPullUp)
      else $error("reset pin pullup off");
   AST_DBG_IN_RESET: assert property (mcuRst |-> !pinDrv.dbgOe && pinDrv.dbgPullUp)
      else $error("debug pin not a pulled-up input");
   AST_MODE: assert property ($fell(mcuRst) && dbgPinIn == $past(dbgPinIn, 4)
      |-> bgMode == !dbgPinIn)
      else $error("mode pick wrong");
   AST_BUS_HALF: assert property ($past(!sys_rst) |-> busClkEn != $past(busClkEn))
      else $error("bus enable not half rate");
   AST_DBG_LOW: assert property (!mcuRst && $past(!mcuRst) && $past(dbgDriveLow) && pinDrv.dbgPullUp
      |-> pinDrv.dbgOe && !pinDrv.dbgOut)
      else $error("debug low not driven");
   AST_BIT_TIME: assert property ($fell(dbgPinIn) && !mcuRst && $past(!mcuRst) && pinDrv.dbgPullUp
      |-> ##[30:38] dbgBitTick)
      else $error("bit time tick off");
endmodule
bind reset_pin_mode_select reset_pin_mode_select_properties #(.SELF_RST_DIV(SELF_RST_DIV)) chk (
   .ref_clk, .sys_rst, .dbgPinIn, .dbgDriveLow, .pinDrv, .mcuRst, .bgMode, .busClkEn,
   .dbgBitTick);
`default_nettype wire

//--- testbench/pin_partner_model.sv
// External reset source and debug pod on the two shared pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner_model (
   input wire logic ref_clk,
   input wire rst_mode_pkg::pinDrv_t pinDrv,
   input wire logic holdRst,
   input wire logic holdDbg,
   output logic rstPin,
   output logic dbgPin
);
   import rst_mode_pkg::*;
   logic flip = 1'b0;
   // An undriven pin without pull wanders, so a stale level is never trusted
   always @(posedge ref_clk) begin
      flip <= ~flip;
   end
   // Far side only ever pulls low, open-drain style
   assign rstPin = holdRst ? 1'b0 : pinDrv.rstOe ? pinDrv.rstOut : pinDrv.rstPullUp | flip;
   assign dbgPin = holdDbg ? 1'b0 : pinDrv.dbgOe ? pinDrv.dbgOut : pinDrv.dbgPullUp | flip;
endmodule
`default_nettype wire

//--- testbench/test_reset_pin_mode_select.sv
// Self-checking bench for the reset pin and mode-select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   total_checks++; \
   if ((a) !== (b)) begin \
      errors++; \
      $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
   end \
end
module test_reset_pin_mode_select;
   import rst_mode_pkg::*;
   localparam int DIV = 2;
   logic ref_clk, sys_rst, rtiOscIn, dbgDriveLow, dbgSpeedup, holdRst, holdDbg;
   logic [INT_SRC_W-1:0] intRstReq;
   ahbReq_t ahbReq;
   ahbRsp_t ahbRsp;
   pinDrv_t pinDrv;
   pulls_t pulls;
   wire logic rstPinIn, dbgPinIn;
   logic mcuRst, bgMode, cpuClkEn, busClkEn, rtiClkEn, dbgBitTick, irq;
   int errors = 0;
   int total_checks = 0;
   int n1, n2;
   reset_pin_mode_select #(.SELF_RST_DIV(DIV)) dut (.ref_clk, .sys_rst, .ahbReq, .ahbRsp,
      .rstPinIn, .dbgPinIn, .rtiOscIn, .intRstReq, .dbgDriveLow, .dbgSpeedup, .pinDrv,
      .pulls, .mcuRst, .bgMode, .cpuClkEn, .busClkEn, .rtiClkEn, .dbgBitTick, .irq);
   pin_partner_model pod (.ref_clk, .pinDrv, .holdRst, .holdDbg, .rstPin(rstPinIn),
      .dbgPin(dbgPinIn));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic close_out();
      $display("Compares %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic bail();
      errors++;
      close_out();
   endtask
   // Watches the live signal: a bit-time tick when onTick, else the end of reset
   task automatic tick(output int n, input logic onTick, input int lim);
      n = 0;
      while ((onTick ? dbgBitTick !== 1'b1 : mcuRst !== 1'b0) && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= lim) bail();
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int n;
      ahbReq.htrans <= 2'h2;
      ahbReq.haddr <= {24'h0, a};
      ahbReq.hwrite <= w;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (ahbRsp.hreadyout !== 1'b1 && n < 50);
         if (n >= 50) bail();
         ahbReq.htrans <= 2'h0;
         ahbReq.hwdata <= d;
      end
      r = ahbRsp.hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      `CHK(x, e)
   endtask
   // Waits out one reset sequence; drive and release lengths land in n1 and n2
   task automatic seqTimes(input int relAt, input logic hd);
      int n;
      n = 0;
      while (mcuRst !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      holdDbg <= hd;
      n1 = 0;
      while (pinDrv.rstOe === 1'b1 && n1 < 400) begin
         @(posedge ref_clk);
         n1++;
      end
      n2 = 0;
      while (mcuRst !== 1'b0 && n2 < 400) begin
         @(posedge ref_clk);
         n2++;
         if (n2 == relAt) holdRst <= 1'b0;
      end
      holdDbg <= 1'b0;
      if (n >= 20 || n1 >= 400 || n2 >= 400) bail();
      `CHK(n1 >= 34 * DIV - 2 && n1 <= 34 * DIV + 3, 1'b1)
      `CHK(n2 >= 38 * DIV - 2 && n2 <= 38 * DIV + 3, 1'b1)
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      bail();
   end
   initial begin
      sys_rst = 1'b1;
      ahbReq = '0;
      ahbReq.hsel = 1'b1;
      ahbReq.hready = 1'b1;
      ahbReq.hsize = 3'h2;
      {intRstReq, rtiOscIn, dbgDriveLow, dbgSpeedup, holdRst, holdDbg} = '0;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      seqTimes(-1, 1'b0);
      rdChk(OFS_CAUSE, 32'h1 << CAUSE_POR);
      `CHK({cpuClkEn, ahbRsp.hresp}, 2'b10)
      rdChk(OFS_SYSOPT, 32'h3);
      rdChk(8'h24, 32'h0);
      for (int i = 0; i < INT_SRC_W; i++) begin
         wr(OFS_SYSOPT, 32'h2);
         intRstReq <= 4'h1 << i;
         @(posedge ref_clk);
         intRstReq <= '0;
         seqTimes(-1, i == 3);
         `CHK(bgMode, i == 3)
         rdChk(OFS_CAUSE, 32'h4 << i);
         rdChk(OFS_SYSOPT, 32'h3);
      end
      holdRst <= 1'b1;
      seqTimes(38 * DIV - 1, 1'b0);
      rdChk(OFS_CAUSE, 32'h1 << CAUSE_PIN);
      repeat (8) @(posedge ref_clk);
      tick(n1, 1'b0, 400);
      // Pins as plain outputs: a low reset pin must not reset the part
      wr(OFS_SYSOPT, 32'h0);
      wr(OFS_PINCTL, 32'h2);
      repeat (8) @(posedge ref_clk);
      `CHK({pinDrv.rstOe, pinDrv.rstOut, pinDrv.dbgOe, pinDrv.dbgOut}, 4'hB)
      `CHK(mcuRst, 1'b0)
      wr(OFS_PINCTL, 32'h3);
      wr(OFS_SYSOPT, 32'h3);
      wr(OFS_IRQ_MASK, 32'h3);
      dbgDriveLow <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK({pinDrv.dbgOe, pinDrv.dbgOut}, 2'b10)
      dbgDriveLow <= 1'b0;
      dbgSpeedup <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK({pinDrv.dbgOe, pinDrv.dbgOut}, 2'b11)
      dbgSpeedup <= 1'b0;
      tick(n1, 1'b1, 60);
      `CHK(n1 + 4 >= 2 * DBG_BIT_CYC && n1 + 4 <= 2 * DBG_BIT_CYC + 8, 1'b1)
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      rdChk(OFS_IRQ_STAT, 32'h3);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MASK, 32'h0);
      holdDbg <= 1'b1;
      @(posedge ref_clk);
      holdDbg <= 1'b0;
      tick(n1, 1'b1, 60);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      rdChk(OFS_IRQ_STAT, 32'h3);
      wr(OFS_PORT, 32'hFF);
      wr(OFS_KEYPAD, 32'hAF);
      wr(OFS_PINCTL, 32'hF);
      repeat (2) @(posedge ref_clk);
      `CHK({pulls.kpPullUp, pulls.kpPullDn, pulls.irqPullUp, pulls.irqPullDn}, 10'h169)
      wr(OFS_PORT, 32'hF0FF);
      wr(OFS_PINCTL, 32'h3);
      repeat (2) @(posedge ref_clk);
      `CHK({pulls.kpPullDn, pulls.irqPullUp, pulls.irqPullDn, pulls.portPullUp}, 14'h0F)
      wr(OFS_SYSOPT, 32'h7);
      repeat (3) @(posedge ref_clk);
      `CHK(rtiClkEn, 1'b1)
      wr(OFS_SYSOPT, 32'h3);
      repeat (4) @(posedge ref_clk);
      n1 = 0;
      rtiOscIn <= 1'b1;
      repeat (8) begin
         @(posedge ref_clk);
         n1 += int'(rtiClkEn);
      end
      `CHK(n1 == 1, 1'b1)
      close_out();
   end
endmodule
`default_nettype wire
